/* File: fst_core.sv */
// fp_status_word, control word, tag word and operand-class bookkeeping
`default_nettype none

module fst_core #(
	parameter int NUM_REGS = fst_pkg::NUM_DATA_REGS
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// operation request from the instruction sequencer
	input wire logic op_valid,
	input wire logic [fst_pkg::OP_W-1:0] op_code,
	input wire logic [2:0] op_reg,
	input wire logic [fst_pkg::EXT_W-1:0] op_data,
	input wire logic [fst_pkg::WORD_W-1:0] op_word,
	input wire logic op_flag,
	input wire logic [3:0] op_cc,
	// architectural words
	output logic [fst_pkg::WORD_W-1:0] fp_status_word,
	output logic [fst_pkg::WORD_W-1:0] fp_control_word,
	output logic [fst_pkg::WORD_W-1:0] fp_tag_word,
	output logic tag_word_valid,
	// operand check results
	output logic invalid_event,
	output logic invalid_unmasked,
	output logic [2:0] operand_class,
	// register read-back
	output logic [fst_pkg::EXT_W-1:0] reg_read_data,
	output logic affine_closure
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the tag word is exactly one two-bit tag per register
	if (NUM_REGS * fst_pkg::TAG_W != fst_pkg::WORD_W) begin : g_bad_regs
		$error("NUM_REGS must fill the 16-bit tag word");
	end

	// ----------------------------------------
	// classification helpers
	// ----------------------------------------
	// decide the class of an extended value from its bits alone
	function automatic fst_pkg::fst_class_e class_of(input logic [fst_pkg::EXT_W-1:0] v);
		logic [14:0] e;
		logic ib;
		logic [62:0] f;
		fst_pkg::fst_class_e c;
		e = v[fst_pkg::EXP_MSB:fst_pkg::EXP_LSB];
		ib = v[fst_pkg::INT_BIT];
		f = v[fst_pkg::INT_BIT-1:0];
		if (e == fst_pkg::EXP_ZERO) begin
			// zero or denormal; integer bit set is a pseudo-denormal, treated as denormal
			if (!ib && f == fst_pkg::FRAC_ZERO) begin
				c = fst_pkg::CLS_ZERO;
			end else begin
				c = fst_pkg::CLS_DENORMAL;
			end
		end else if (!ib) begin
			// pseudo-nan, pseudo-infinity, unnormal and pseudo-zero
			c = fst_pkg::CLS_UNSUPPORTED;
		end else if (e == fst_pkg::EXP_MAX) begin
			if (f == fst_pkg::FRAC_ZERO) begin
				c = fst_pkg::CLS_INFINITY;
			end else if (v[fst_pkg::QUIET_BIT]) begin
				c = fst_pkg::CLS_QUIET_NAN;
			end else begin
				c = fst_pkg::CLS_SIGNALLING_NAN;
			end
		end else begin
			c = fst_pkg::CLS_NORMAL;
		end
		return c;
	endfunction : class_of

	// tag code that matches a class
	function automatic logic [fst_pkg::TAG_W-1:0] tag_of(input fst_pkg::fst_class_e c);
		logic [fst_pkg::TAG_W-1:0] t;
		case (c)
			fst_pkg::CLS_ZERO: begin
				t = fst_pkg::TAG_ZERO;
			end
			fst_pkg::CLS_NORMAL: begin
				t = fst_pkg::TAG_VALID;
			end
			default: begin
				// nan, infinity, denormal and every unsupported encoding
				t = fst_pkg::TAG_SPECIAL;
			end
		endcase
		return t;
	endfunction : tag_of

	// make a value fit to be a result: quiet nans only, no unsupported encodings
	function automatic logic [fst_pkg::EXT_W-1:0] sanitize(input logic [fst_pkg::EXT_W-1:0] v);
		logic [fst_pkg::EXT_W-1:0] r;
		r = v;
		case (class_of(v))
			fst_pkg::CLS_SIGNALLING_NAN: begin
				r[fst_pkg::QUIET_BIT] = 1'b1;
			end
			fst_pkg::CLS_UNSUPPORTED: begin
				r = fst_pkg::QUIET_NAN_INDEFINITE;
			end
			default: begin
				r = v;
			end
		endcase
		return r;
	endfunction : sanitize

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [fst_pkg::EXT_W-1:0] data_reg [0:NUM_REGS-1]; // data register contents
	logic [NUM_REGS-1:0] empty; // per-register empty marks
	logic invalid_flag; // sticky invalid-operation flag
	logic stack_fault_flag; // sticky stack-fault flag
	logic cond_code_zero; // condition code zero
	logic cond_code_one; // condition code one
	logic cond_code_two; // condition code two
	logic cond_code_three; // condition code three
	logic [fst_pkg::WORD_W-1:0] control_reg; // stored control word

	// ----------------------------------------
	// operation decode
	// ----------------------------------------
	wire logic is_init = op_valid && op_code == fst_pkg::OP_INIT;
	wire logic is_prem = op_valid && (op_code == fst_pkg::OP_PREM ||
		op_code == fst_pkg::OP_PREM_IEEE);
	wire logic is_ptan = op_valid && op_code == fst_pkg::OP_PTAN;
	wire logic is_tag_load = op_valid && (op_code == fst_pkg::OP_ENV_LOAD ||
		op_code == fst_pkg::OP_STATE_RESTORE);
	wire logic is_tag_store = op_valid && (op_code == fst_pkg::OP_ENV_STORE ||
		op_code == fst_pkg::OP_STATE_SAVE);
	wire logic is_nan_strict = op_valid && (op_code == fst_pkg::OP_COMPARE ||
		op_code == fst_pkg::OP_INT_STORE || op_code == fst_pkg::OP_BCD_STORE);
	wire logic is_arith = op_valid && op_code == fst_pkg::OP_ARITH;
	wire logic is_load_raw = op_valid && op_code == fst_pkg::OP_LOAD_RAW;
	wire logic is_stack_fault = op_valid && op_code == fst_pkg::OP_STACK_FAULT;
	wire logic is_write_cw = op_valid && op_code == fst_pkg::OP_WRITE_CW;

	// ----------------------------------------
	// operand classification
	// ----------------------------------------
	// the operand's class comes from its bits; of the stored tag only the empty mark is consulted
	wire fst_pkg::fst_class_e op_class = class_of(data_reg[op_reg]);
	wire logic op_is_signalling_nan = op_class == fst_pkg::CLS_SIGNALLING_NAN;
	wire logic op_is_quiet_nan = op_class == fst_pkg::CLS_QUIET_NAN;
	wire logic op_is_unsupp = op_class == fst_pkg::CLS_UNSUPPORTED;
	wire logic op_present = !empty[op_reg];

	// signalling nans fault in arithmetic, compare and stores, quiet ones only for compare and stores
	wire logic nan_invalid = op_present && ((is_arith || is_nan_strict) && op_is_signalling_nan ||
		is_nan_strict && op_is_quiet_nan);
	// unsupported encodings fault in any arithmetic use
	wire logic unsupp_invalid = op_present && (is_arith || is_nan_strict) && op_is_unsupp;
	wire logic operand_invalid = nan_invalid || unsupp_invalid;
	wire logic raise_invalid = operand_invalid || is_stack_fault;
	wire logic invalid_masked = control_reg[fst_pkg::CW_INVALID_MASK_BIT];

	// ----------------------------------------
	// tag word recomputation
	// ----------------------------------------
	logic [fst_pkg::WORD_W-1:0] live_tags; // tags that match current contents

	// each tag is rebuilt from the register bits; empty marks give 11
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_tags
		assign live_tags[i*fst_pkg::TAG_W +: fst_pkg::TAG_W] = empty[i] ?
			fst_pkg::TAG_EMPTY : tag_of(class_of(data_reg[i]));
	end

	// ----------------------------------------
	// next condition codes
	// ----------------------------------------
	logic next_cc0; // next condition code zero
	logic next_cc1; // next condition code one
	logic next_cc2; // next condition code two
	logic next_cc3; // next condition code three

	// condition-code update per operation
	always_comb begin
		next_cc0 = cond_code_zero;
		next_cc1 = cond_code_one;
		next_cc2 = cond_code_two;
		next_cc3 = cond_code_three;
		if (is_init) begin
			// initialize leaves a known state
			next_cc0 = 1'b0;
			next_cc1 = 1'b0;
			next_cc2 = 1'b0;
			next_cc3 = 1'b0;
		end else if (is_prem) begin
			if (op_flag) begin
				// incomplete reduction
				next_cc0 = 1'b0;
				next_cc1 = 1'b0;
				next_cc3 = 1'b0;
				next_cc2 = 1'b1;
			end else begin
				// complete: quotient bits from the datapath
				next_cc0 = op_cc[0];
				next_cc1 = op_cc[1];
				next_cc3 = op_cc[3];
				next_cc2 = 1'b0;
			end
		end else if (is_ptan) begin
			// code two flags an out-of-range operand
			next_cc2 = op_flag;
			next_cc1 = op_cc[1];
		end else if (is_stack_fault) begin
			// overflow sets code one, underflow clears it
			next_cc1 = op_flag;
		end else if (is_nan_strict && op_code == fst_pkg::OP_COMPARE) begin
			// compare result codes from the datapath
			next_cc0 = op_cc[0];
			next_cc2 = op_cc[2];
			next_cc3 = op_cc[3];
		end else begin
			// other operations keep the codes
			next_cc0 = cond_code_zero;
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// sticky flags: only initialize and hardware reset clear them, a set in the same cycle wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			invalid_flag <= 1'b0;
			stack_fault_flag <= 1'b0;
		end else begin
			invalid_flag <= raise_invalid || (invalid_flag && !is_init);
			stack_fault_flag <= is_stack_fault || (stack_fault_flag && !is_init);
		end
	end

	// condition codes, cleared by hardware reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond_code_zero <= 1'b0;
			cond_code_one <= 1'b0;
			cond_code_two <= 1'b0;
			cond_code_three <= 1'b0;
		end else begin
			cond_code_zero <= next_cc0;
			cond_code_one <= next_cc1;
			cond_code_two <= next_cc2;
			cond_code_three <= next_cc3;
		end
	end

	// ----------------------------------------
	// control word
	// ----------------------------------------
	// every bit including infinity control is stored as written
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			control_reg <= fst_pkg::CW_RESET;
		end else if (is_init) begin
			control_reg <= fst_pkg::CW_RESET;
		end else if (is_write_cw) begin
			control_reg <= op_word;
		end
	end

	// ----------------------------------------
	// empty marks
	// ----------------------------------------
	// loaded tags keep only empty or non-empty; writes mark a register full
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			empty <= '1;
		end else if (is_init) begin
			empty <= '1;
		end else if (is_tag_load) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				empty[i] <= op_word[i*fst_pkg::TAG_W +: fst_pkg::TAG_W] ==
					fst_pkg::TAG_EMPTY;
			end
		end else if (is_load_raw || is_arith) begin
			empty[op_reg] <= 1'b0;
		end
	end

	// ----------------------------------------
	// data registers
	// ----------------------------------------
	// raw loads keep any encoding; arithmetic results are made quiet and supported
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				data_reg[i] <= fst_pkg::EXT_ZERO;
			end
		end else if (is_load_raw) begin
			data_reg[op_reg] <= op_data;
		end else if (is_arith) begin
			data_reg[op_reg] <= operand_invalid && invalid_masked ?
				fst_pkg::QUIET_NAN_INDEFINITE : sanitize(op_data);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// tag word image, captured on store operations
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fp_tag_word <= fst_pkg::WORD_ZERO;
			tag_word_valid <= 1'b0;
		end else begin
			tag_word_valid <= is_tag_store;
			if (is_tag_store) begin
				fp_tag_word <= live_tags;
			end
		end
	end

	// exception pulses and operand class report
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			invalid_event <= 1'b0;
			invalid_unmasked <= 1'b0;
			operand_class <= fst_pkg::CLS_ZERO;
			reg_read_data <= fst_pkg::EXT_ZERO;
		end else begin
			invalid_event <= raise_invalid;
			invalid_unmasked <= raise_invalid && !invalid_masked;
			operand_class <= op_class;
			reg_read_data <= data_reg[op_reg];
		end
	end

	// status word image; unused bits read zero
	always_comb begin
		fp_status_word = fst_pkg::WORD_ZERO;
		fp_status_word[fst_pkg::SW_INVALID_BIT] = invalid_flag;
		fp_status_word[fst_pkg::SW_STACK_FAULT_BIT] = stack_fault_flag;
		fp_status_word[fst_pkg::SW_CC0_BIT] = cond_code_zero;
		fp_status_word[fst_pkg::SW_CC1_BIT] = cond_code_one;
		fp_status_word[fst_pkg::SW_CC2_BIT] = cond_code_two;
		fp_status_word[fst_pkg::SW_CC3_BIT] = cond_code_three;
	end

	// control word reads back as written; closure is affine whatever bit 12 says
	assign fp_control_word = control_reg;
	assign affine_closure = 1'b1;

endmodule : fst_core

`default_nettype wire

/* File: fst_pkg.sv */
// constants and encodings shared by the fpu status, tag and nan bookkeeping
`default_nettype none

package fst_pkg;

	// ----------------------------------------
	// widths of words and register contents
	// ----------------------------------------
	localparam int WORD_W = 16; // status, control and tag words
	localparam int EXT_W = 80; // extended-precision register contents
	localparam int TAG_W = 2; // one tag per data register
	localparam int NUM_DATA_REGS = 8; // depth of the data register stack
	localparam int OP_W = 4; // width of the operation code port

	// ----------------------------------------
	// status word field positions
	// ----------------------------------------
	localparam int SW_INVALID_BIT = 0; // invalid-operation flag
	localparam int SW_STACK_FAULT_BIT = 6; // stack-fault flag
	localparam int SW_CC0_BIT = 8; // condition code zero
	localparam int SW_CC1_BIT = 9; // condition code one
	localparam int SW_CC2_BIT = 10; // condition code two
	localparam int SW_CC3_BIT = 14; // condition code three

	// ----------------------------------------
	// control word fields and reset value
	// ----------------------------------------
	localparam int CW_INVALID_MASK_BIT = 0; // masks the invalid-operation exception
	localparam int CW_INFINITY_BIT = 12; // infinity control, stored but ignored
	localparam logic [WORD_W-1:0] CW_RESET = 16'h037f; // control word after reset and init
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000; // cleared word

	// ----------------------------------------
	// tag codes
	// ----------------------------------------
	localparam logic [TAG_W-1:0] TAG_VALID = 2'h0; // normal finite value
	localparam logic [TAG_W-1:0] TAG_ZERO = 2'h1; // true zero
	localparam logic [TAG_W-1:0] TAG_SPECIAL = 2'h2; // nan, infinity, denormal, unsupported
	localparam logic [TAG_W-1:0] TAG_EMPTY = 2'h3; // empty location

	// ----------------------------------------
	// extended-precision field layout
	// ----------------------------------------
	localparam int EXP_MSB = 78; // top bit of the biased exponent
	localparam int EXP_LSB = 64; // bottom bit of the biased exponent
	localparam int INT_BIT = 63; // explicit integer bit
	localparam int QUIET_BIT = 62; // top fraction bit, set on a quiet nan
	localparam logic [14:0] EXP_ZERO = 15'h0000; // exponent of zeros and denormals
	localparam logic [14:0] EXP_MAX = 15'h7fff; // exponent of infinities and nans
	localparam logic [62:0] FRAC_ZERO = 63'h0; // empty fraction
	localparam logic [EXT_W-1:0] QUIET_NAN_INDEFINITE = 80'hffff_c000_0000_0000_0000; // default quiet nan
	localparam logic [EXT_W-1:0] EXT_ZERO = 80'h0; // cleared register contents

	// ----------------------------------------
	// operation codes presented by the instruction sequencer
	// ----------------------------------------
	typedef enum logic [OP_W-1:0] {
		OP_NONE = 4'h0, // idle
		OP_INIT = 4'h1, // unit initialize
		OP_PREM = 4'h2, // partial remainder
		OP_PREM_IEEE = 4'h3, // ieee partial remainder
		OP_PTAN = 4'h4, // partial tangent
		OP_ENV_LOAD = 4'h5, // environment load, tag word in op_word
		OP_STATE_RESTORE = 4'h6, // state restore, tag word in op_word
		OP_ENV_STORE = 4'h7, // environment store, tag word out
		OP_STATE_SAVE = 4'h8, // state save, tag word out
		OP_COMPARE = 4'h9, // compare, operand op_reg
		OP_INT_STORE = 4'ha, // integer store, operand op_reg
		OP_BCD_STORE = 4'hb, // packed decimal store, operand op_reg
		OP_ARITH = 4'hc, // arithmetic operand check, then result write
		OP_LOAD_RAW = 4'hd, // explicit software load of a register
		OP_STACK_FAULT = 4'he, // stack overflow (op_flag=1) or underflow
		OP_WRITE_CW = 4'hf // control word write from op_word
	} fst_op_e;

	// ----------------------------------------
	// operand classes taken from register contents
	// ----------------------------------------
	typedef enum logic [2:0] {
		CLS_ZERO = 3'h0,
		CLS_NORMAL = 3'h1,
		CLS_DENORMAL = 3'h2,
		CLS_INFINITY = 3'h3,
		CLS_QUIET_NAN = 3'h4,
		CLS_SIGNALLING_NAN = 3'h5,
		CLS_UNSUPPORTED = 3'h6
	} fst_class_e;

endpackage : fst_pkg

`default_nettype wire

/* File: fst_core_unused_guard.sv */
// intentionally minimal: no additional logic lives outside fst_core
`default_nettype none
`default_nettype wire

/* File: fst_core_monitor.sv */
// concurrent checks on the status, control and tag bookkeeping ports
`default_nettype none

module fst_core_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// operation request
	input wire logic op_valid,
	input wire logic [fst_pkg::OP_W-1:0] op_code,
	input wire logic [fst_pkg::WORD_W-1:0] op_word,
	input wire logic op_flag,
	input wire logic [3:0] op_cc,
	// observed words and pulses
	input wire logic [fst_pkg::WORD_W-1:0] fp_status_word,
	input wire logic [fst_pkg::WORD_W-1:0] fp_control_word,
	input wire logic tag_word_valid,
	input wire logic invalid_event,
	input wire logic invalid_unmasked,
	input wire logic affine_closure
);
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ----------------
	// decoded requests
	// ----------------
	wire logic is_init = op_valid && op_code == fst_pkg::OP_INIT;
	wire logic is_prem = op_valid && (op_code == fst_pkg::OP_PREM
		|| op_code == fst_pkg::OP_PREM_IEEE);
	wire logic is_ptan = op_valid && op_code == fst_pkg::OP_PTAN;
	wire logic is_fault = op_valid && op_code == fst_pkg::OP_STACK_FAULT;
	wire logic is_cw = op_valid && op_code == fst_pkg::OP_WRITE_CW;
	wire logic is_store = op_valid && (op_code == fst_pkg::OP_ENV_STORE
		|| op_code == fst_pkg::OP_STATE_SAVE);
	// ----------------
	// assertions
	// ----------------
	chk_reserved_bits_zero: assert property (
		(fp_status_word & 16'hb8be) == 16'h0000) else $error("reserved status bit set");
	chk_prem_cc_field: assert property (
		is_prem |=> ($past(op_flag) ? (fp_status_word & 16'h4700) == 16'h0400
		: (fp_status_word & 16'h4700) == {1'b0, $past(op_cc[3]), 3'h0, 1'b0,
		$past(op_cc[1]), $past(op_cc[0]), 8'h00})) else $error("remainder cc wrong");
	chk_cc_init_clear: assert property (
		is_init |=> (fp_status_word & 16'h4700) == 16'h0000) else $error("init kept cc");
	chk_ptan_range_flag: assert property (
		is_ptan |=> fp_status_word[10] == $past(op_flag)) else $error("tangent cc2 wrong");
	chk_fault_flags_set: assert property (
		is_fault |=> fp_status_word[0] && fp_status_word[6] && invalid_event)
		else $error("stack fault flags missing");
	chk_fault_direction: assert property (
		is_fault |=> fp_status_word[9] == $past(op_flag)) else $error("fault cc1 wrong");
	chk_cw_written: assert property (
		is_cw |=> fp_control_word == $past(op_word)) else $error("control word not stored");
	chk_affine_always: assert property (
		affine_closure) else $error("projective closure seen");
	chk_store_pulse: assert property (
		is_store |=> tag_word_valid) else $error("tag word pulse missing");
	chk_unmasked_gate: assert property (
		invalid_unmasked |-> invalid_event && !fp_control_word[0])
		else $error("unmasked invalid while masked");
endmodule : fst_core_monitor

bind fst_core fst_core_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
	.op_code(op_code), .op_word(op_word), .op_flag(op_flag), .op_cc(op_cc),
	.fp_status_word(fp_status_word), .fp_control_word(fp_control_word),
	.tag_word_valid(tag_word_valid), .invalid_event(invalid_event),
	.invalid_unmasked(invalid_unmasked), .affine_closure(affine_closure));

`default_nettype wire

/* File: fst_core_bench.sv */
// self-checking bench for the fpu status, tag and nan bookkeeping
`default_nettype none

module fst_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// signals
	// ----------------
	logic clk, sys_rst, op_valid, op_flag;
	logic [3:0] op_code, op_cc;
	logic [2:0] op_reg, operand_class;
	logic [79:0] op_data, reg_read_data, d;
	logic [15:0] op_word, fp_status_word, fp_control_word, fp_tag_word, w;
	logic tag_word_valid, invalid_event, invalid_unmasked, affine_closure, inv;
	logic [3:0] c;
	logic f;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	logic [79:0] model [8]; // expected register contents
	logic [79:0] corner [8] = '{80'h0, 80'h3fff_8000_0000_0000_0000,
		80'h0000_0000_0000_0000_0001, 80'h7fff_8000_0000_0000_0000,
		80'h7fff_c000_0000_0000_0001, 80'h7fff_a000_0000_0000_0000,
		80'h0001_4000_0000_0000_0000, 80'h7fff_0000_0000_0000_0000};

	fst_core #(.NUM_REGS(8)) dut_u (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
		.op_code(op_code), .op_reg(op_reg), .op_data(op_data), .op_word(op_word),
		.op_flag(op_flag), .op_cc(op_cc), .fp_status_word(fp_status_word),
		.fp_control_word(fp_control_word), .fp_tag_word(fp_tag_word),
		.tag_word_valid(tag_word_valid), .invalid_event(invalid_event),
		.invalid_unmasked(invalid_unmasked), .operand_class(operand_class),
		.reg_read_data(reg_read_data), .affine_closure(affine_closure));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			n_fail++;
			end_sim();
		end
	end

	// ----------------
	// expectation functions
	// ----------------
	function automatic logic [2:0] cls_of(input logic [79:0] v);
		if (v[78:64] == 15'h0000) return (v[63:0] == 64'h0) ? 3'h0 : 3'h2;
		if (!v[63]) return 3'h6; // unnormal and pseudo forms
		if (v[78:64] != 15'h7fff) return 3'h1;
		if (v[62:0] == 63'h0) return 3'h3;
		return v[62] ? 3'h4 : 3'h5;
	endfunction : cls_of

	function automatic logic [1:0] tag_of(input logic [2:0] k);
		return (k == 3'h0) ? 2'h1 : (k == 3'h1) ? 2'h0 : 2'h2;
	endfunction : tag_of

	// tags after a store: empty kept, others from contents
	function automatic logic [15:0] exp_tags(input logic [15:0] ld);
		logic [15:0] t;
		for (int i = 0; i < 8; i++) begin
			t[2*i +: 2] = (ld[2*i +: 2] == 2'h3) ? 2'h3 : tag_of(cls_of(model[i]));
		end
		return t;
	endfunction : exp_tags

	// invalid expected from an operand check
	function automatic logic exp_inv(input logic [3:0] code, input logic [79:0] v);
		logic [2:0] k;
		k = cls_of(v);
		if (code == 4'hc) return k == 3'h5 || k == 3'h6;
		return k == 3'h4 || k == 3'h5 || k == 3'h6;
	endfunction : exp_inv

	function automatic logic [79:0] sanitize(input logic [79:0] v);
		if (cls_of(v) == 3'h5) return v | {17'h0, 1'b1, 62'h0};
		if (cls_of(v) == 3'h6) return fst_pkg::QUIET_NAN_INDEFINITE;
		return v;
	endfunction : sanitize

	// ----------------
	// tasks
	// ----------------
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one-cycle request, returns with its answer settled
	task automatic op(input logic [3:0] code, input logic [2:0] r, input logic [79:0] dv,
		input logic [15:0] wd, input logic fl, input logic [3:0] cc);
		@(negedge clk);
		op_valid = 1'b1;
		op_code = code;
		op_reg = r;
		op_data = dv;
		op_word = wd;
		op_flag = fl;
		op_cc = cc;
		@(negedge clk);
		op_valid = 1'b0;
	endtask : op

	// read-back of one register
	task automatic peek(input logic [2:0] r);
		op_reg = r;
		@(negedge clk);
		check(operand_class, cls_of(model[r]));
		check(reg_read_data, model[r]);
	endtask : peek

	task automatic end_sim();
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// ----------------
	// main sequence
	// ----------------
	initial begin
		{sys_rst, op_valid, op_code, op_reg, op_data, op_word, op_flag, op_cc} = '0;
		sys_rst = 1'b1;
		void'($urandom(9));
		repeat (2) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		check(fp_status_word, 16'h0000);
		check(fp_control_word, fst_pkg::CW_RESET);
		// remainder and tangent condition codes
		for (int k = 0; k < 8; k++) begin
			c = 4'($urandom);
			f = 1'($urandom);
			op(k[0] ? 4'h3 : 4'h2, 3'h0, 80'h0, 16'h0, f, c);
			check(fp_status_word & 16'h4700, f ? 16'h0400 :
				{1'b0, c[3], 4'h0, c[1], c[0], 8'h00});
			op(4'h4, 3'h0, 80'h0, 16'h0, ~f, c);
			check(fp_status_word[10], !f);
		end
		op(4'h2, 3'h0, 80'h0, 16'h0, 1'b0, 4'hf);
		op(4'h1, 3'h0, 80'h0, 16'h0, 1'b0, 4'h0);
		check(fp_status_word & 16'h4700, 16'h0000);
		// hardware reset in mid-run must clear codes left by a remainder
		op(4'h2, 3'h0, 80'h0, 16'h0, 1'b0, 4'hf);
		check(fp_status_word & 16'h4700, 16'h4300);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		check(fp_status_word, 16'h0000);
		// stack faults, masked then unmasked
		for (int k = 0; k < 4; k++) begin
			if (k == 2) begin
				w = {3'h0, 1'($urandom), 12'h37e};
				op(4'hf, 3'h0, 80'h0, w, 1'b0, 4'h0);
				check(fp_control_word, w);
				check(affine_closure, 1'b1);
			end
			op(4'he, 3'h0, 80'h0, 16'h0, k[0], 4'h0);
			check(fp_status_word & 16'h0241, {6'h00, k[0], 2'h0, 1'b1, 5'h00, 1'b1});
			check(invalid_event, 1'b1);
			check(invalid_unmasked, k >= 2);
		end
		op(4'h1, 3'h0, 80'h0, 16'h0, 1'b0, 4'h0);
		check(fp_status_word, 16'h0000);
		check(fp_control_word, fst_pkg::CW_RESET);
		// one encoding of each class per register
		for (int i = 0; i < 8; i++) begin
			model[i] = corner[i];
			op(4'hd, 3'(i), corner[i], 16'h0, 1'b0, 4'h0);
		end
		for (int i = 0; i < 8; i++) peek(3'(i));
		// tag word load and store pairs
		for (int k = 0; k < 4; k++) begin
			w = 16'($urandom);
			op(k[0] ? 4'h6 : 4'h5, 3'h0, 80'h0, w, 1'b0, 4'h0);
			op(k[1] ? 4'h8 : 4'h7, 3'h0, 80'h0, 16'h0, 1'b0, 4'h0);
			check(tag_word_valid, 1'b1);
			check(fp_tag_word, exp_tags(w));
		end
		// operand checks, masked round then unmasked round
		for (int rnd = 0; rnd < 2; rnd++) begin
			w = rnd ? 16'($urandom) : 16'h0000;
			op(4'h5, 3'h0, 80'h0, w, 1'b0, 4'h0);
			if (rnd == 1) op(4'hf, 3'h0, 80'h0, 16'h037e, 1'b0, 4'h0);
			for (int i = 0; i < 8; i++) begin
				for (int code = 9; code < 12; code++) begin
					op(4'(code), 3'(i), 80'h0, 16'h0, 1'b0, 4'h0);
					inv = (w[2*i +: 2] != 2'h3) && exp_inv(4'(code), model[i]);
					check(invalid_event, inv);
					check(invalid_unmasked, inv && rnd == 1);
				end
				if (w[2*i +: 2] != 2'h3) begin
					d = 1'($urandom) ? corner[3'($urandom)] :
						{16'($urandom), 32'($urandom), 32'($urandom)};
					inv = exp_inv(4'hc, model[i]);
					op(4'hc, 3'(i), d, 16'h0, 1'b0, 4'h0);
					check(invalid_event, inv);
					model[i] = (inv && rnd == 0) ? fst_pkg::QUIET_NAN_INDEFINITE : sanitize(d);
					peek(3'(i));
				end
			end
			op(4'h7, 3'h0, 80'h0, 16'h0, 1'b0, 4'h0);
			check(fp_tag_word, exp_tags(w));
		end
		end_sim();
	end
endmodule : fst_core_bench

`default_nettype wire
